// File: pkg/aqc_pkg.sv
// Notes on behaviour
// - one conversion per software command
// - hardware pacing from internal or external clock
// - hardware triggers only in hardware-paced timing
// - buffered hardware-paced mode streams FIFO blocks to host
// - non-buffered mode host reads single samples
// - finite mode stops at preset count
// - reference trigger only in finite mode
// - continuous mode runs until stop command
// - FIFO overwrite flags overrun error
// - start, reference and pause trigger actions
// - digital triggers always, analog optional
// - start trigger or software start begins
// - end on count, reference or stop
// - load gain range before sampling channel
// - pause gates sample clock by level
package aqc_pkg;
    localparam int SAMPLE_W = 16;
    localparam int COUNT_W = 24;
    localparam int CHAN_W = 4;
    localparam int RANGE_W = 3;
    localparam int FIFO_AW = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int DIV_W = 16;
    localparam int SCAN_LEN = 16;
    localparam logic [DIV_W-1:0] DIV_RESET = 16'h0018;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h00_0000;
    localparam logic [FIFO_AW:0] LEVEL_RESET = 5'h00;
    localparam bit HAS_ANALOG_TRIG = 1'b0;

    typedef enum logic [3:0] {
        AQC_IDLE = 4'b0001,
        AQC_ARMED = 4'b0010,
        AQC_RUN = 4'b0100,
        AQC_POST = 4'b1000
    } aqc_state_e;
endpackage

// File: hdl/aqc_acquisition_control.sv
`timescale 1ns/1ps
`default_nettype none
module aqc_acquisition_control (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // configuration
    input wire logic hw_paced,
    input wire logic buffered,
    input wire logic finite_mode,
    input wire logic ext_clock_sel,
    input wire logic [aqc_pkg::DIV_W-1:0] sample_div,
    input wire logic [aqc_pkg::COUNT_W-1:0] sample_count,
    input wire logic [aqc_pkg::COUNT_W-1:0] pretrig_count,
    input wire logic begin_trig_en,
    input wire logic begin_trig_falling,
    input wire logic ref_trig_en,
    input wire logic ref_trig_falling,
    input wire logic pause_en,
    input wire logic pause_active_high,
    input wire logic analog_trig_sel,
    input wire logic [aqc_pkg::CHAN_W-1:0] scan_last,
    input wire logic [aqc_pkg::RANGE_W-1:0] scan_range [aqc_pkg::SCAN_LEN],
    input wire logic [aqc_pkg::CHAN_W-1:0] scan_chan [aqc_pkg::SCAN_LEN],
    // software commands, one-cycle pulses
    input wire logic sw_arm,
    input wire logic sw_start,
    input wire logic sw_stop,
    input wire logic sw_convert,
    input wire logic overrun_clear,
    // pins from outside the clock domain
    input wire logic ext_sample_clk,
    input wire logic acq_begin_trigger,
    input wire logic acq_reference_stop_trigger,
    input wire logic acq_pause_gate,
    input wire logic analog_compare,
    // converter
    output logic conv_start,
    output logic [aqc_pkg::CHAN_W-1:0] mux_chan,
    output logic [aqc_pkg::RANGE_W-1:0] programmable_gain_amp,
    input wire logic conv_done,
    input wire logic [aqc_pkg::SAMPLE_W-1:0] conv_data,
    // sample drain: dma block stream or single reads
    output logic dma_valid,
    output logic [aqc_pkg::SAMPLE_W-1:0] dma_data,
    input wire logic dma_ready,
    input wire logic host_read,
    output logic [aqc_pkg::SAMPLE_W-1:0] host_data,
    output logic host_data_valid,
    // status
    output logic acq_busy,
    output logic acq_done,
    output logic overrun_err,
    output logic ref_cfg_err,
    output logic [aqc_pkg::FIFO_AW:0] fifo_level
);
    import aqc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change accepted when 2nd and 3rd agree
    logic [4:0] pin_a_r, pin_b_r, pin_c_r, pin_q_r;
    logic [4:0] pin_a_nxt, pin_q_nxt, pin_rise, pin_fall;
    always_comb begin
        pin_a_nxt = {analog_compare, acq_pause_gate, acq_reference_stop_trigger,
                     acq_begin_trigger, ext_sample_clk};
        pin_q_nxt = pin_q_r;
        for (int i = 0; i < 5; i++) begin
            if (pin_b_r[i] == pin_c_r[i]) begin
                pin_q_nxt[i] = pin_c_r[i];
            end
        end
        pin_rise = pin_q_nxt & ~pin_q_r;
        pin_fall = ~pin_q_nxt & pin_q_r;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pin_a_r <= 5'h00;
            pin_b_r <= 5'h00;
            pin_c_r <= 5'h00;
            pin_q_r <= 5'h00;
        end else begin
            pin_a_r <= pin_a_nxt;
            pin_b_r <= pin_a_r;
            pin_c_r <= pin_b_r;
            pin_q_r <= pin_q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger decode
    logic use_analog, begin_evt, ref_evt, paused, hw_trig_ok;
    always_comb begin
        use_analog = analog_trig_sel && HAS_ANALOG_TRIG;
        hw_trig_ok = hw_paced;
        begin_evt = hw_trig_ok && begin_trig_en && (use_analog ? pin_rise[4] :
                    (begin_trig_falling ? pin_fall[1] : pin_rise[1]));
        ref_evt = hw_trig_ok && ref_trig_en && finite_mode && (use_analog ? pin_rise[4] :
                  (ref_trig_falling ? pin_fall[2] : pin_rise[2]));
        paused = hw_trig_ok && pause_en && (use_analog ? pin_q_r[4] :
                 (pin_q_r[3] == pause_active_high));
    end

    ////////////////////////////////////////////////////////////////////////////
    // acquisition sequencer
    aqc_state_e state_r, state_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic [COUNT_W-1:0] cnt_r, cnt_nxt, post_r, post_nxt;
    logic [CHAN_W-1:0] step_r, step_nxt, chan_r, chan_nxt;
    logic busy_r, busy_nxt, done_r, done_nxt, cerr_r, cerr_nxt;
    logic conv_r, conv_nxt, inflight_r, inflight_nxt, tick, stop_now, push;
    logic [RANGE_W-1:0] gain_r, gain_nxt;
    always_comb begin
        state_nxt = state_r;
        div_nxt = div_r;
        cnt_nxt = cnt_r;
        post_nxt = post_r;
        step_nxt = step_r;
        done_nxt = done_r;
        cerr_nxt = cerr_r;
        conv_nxt = 1'b0;
        inflight_nxt = inflight_r;
        chan_nxt = chan_r;
        gain_nxt = gain_r;
        tick = 1'b0;
        push = conv_done && inflight_r;
        if (push) begin
            inflight_nxt = 1'b0;
        end
        if (ext_clock_sel) begin
            tick = pin_rise[0];
        end else if (div_r == '0) begin
            tick = 1'b1;
        end
        if (state_r == AQC_RUN || state_r == AQC_POST) begin
            div_nxt = (div_r == '0) ? sample_div : div_r - 1'b1;
        end
        stop_now = sw_stop
                   || (state_r == AQC_RUN && finite_mode && !ref_trig_en && cnt_r >= sample_count)
                   || (state_r == AQC_POST && post_r == '0);
        unique case (state_r)
            AQC_IDLE: begin
                if (sw_arm) begin
                    cerr_nxt = ref_trig_en && !finite_mode;
                    if (!(ref_trig_en && !finite_mode) && hw_paced) begin
                        state_nxt = AQC_ARMED;
                        cnt_nxt = COUNT_RESET;
                        done_nxt = 1'b0;
                        step_nxt = '0;
                        div_nxt = sample_div;
                    end
                end else if (!hw_paced && sw_convert && !inflight_r) begin
                    conv_nxt = 1'b1;
                    inflight_nxt = 1'b1;
                    chan_nxt = scan_chan[0];
                    gain_nxt = scan_range[0];
                end
            end
            AQC_ARMED: begin
                // begin on trigger or software start
                if (sw_stop) begin
                    state_nxt = AQC_IDLE;
                end else if (sw_start || begin_evt) begin
                    state_nxt = AQC_RUN;
                    chan_nxt = scan_chan[0];
                    gain_nxt = scan_range[0];
                end
            end
            AQC_RUN, AQC_POST: begin
                if (stop_now) begin
                    state_nxt = AQC_IDLE;
                    done_nxt = 1'b1;
                end else begin
                    if (state_r == AQC_RUN && ref_evt && cnt_r >= pretrig_count) begin
                        state_nxt = AQC_POST;
                        post_nxt = (sample_count > pretrig_count) ?
                                   sample_count - pretrig_count : '0;
                    end
                    if (tick && !paused && !inflight_r) begin
                        conv_nxt = 1'b1;
                        inflight_nxt = 1'b1;
                        cnt_nxt = cnt_r + 1'b1;
                        if (state_r == AQC_POST && post_r != '0) begin
                            post_nxt = post_r - 1'b1;
                        end
                        step_nxt = (step_r == scan_last) ? '0 : step_r + 1'b1;
                    end
                    // next range settles before next conversion
                    if (conv_r) begin
                        chan_nxt = scan_chan[step_r];
                        gain_nxt = scan_range[step_r];
                    end
                end
            end
        endcase
        busy_nxt = (state_nxt != AQC_IDLE);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= AQC_IDLE;
            div_r <= DIV_RESET;
            cnt_r <= COUNT_RESET;
            post_r <= COUNT_RESET;
            step_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cerr_r <= 1'b0;
            conv_r <= 1'b0;
            inflight_r <= 1'b0;
            chan_r <= '0;
            gain_r <= '0;
        end else begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
            post_r <= post_nxt;
            step_r <= step_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            cerr_r <= cerr_nxt;
            conv_r <= conv_nxt;
            inflight_r <= inflight_nxt;
            chan_r <= chan_nxt;
            gain_r <= gain_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample fifo; full fifo overwrites its oldest entry
    logic [SAMPLE_W-1:0] mem_r [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [FIFO_AW:0] lvl_r, lvl_nxt;
    logic ovr_r, ovr_nxt, full, pop, dv_r, dv_nxt, hv_r, hv_nxt;
    logic [SAMPLE_W-1:0] dd_r, dd_nxt, hd_r, hd_nxt;
    always_comb begin
        full = (lvl_r == FIFO_DEPTH[FIFO_AW:0]);
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        lvl_nxt = lvl_r;
        ovr_nxt = ovr_r;
        dv_nxt = dv_r;
        dd_nxt = dd_r;
        hv_nxt = 1'b0;
        hd_nxt = hd_r;
        pop = 1'b0;
        if (buffered && hw_paced) begin
            if (dv_r && dma_ready) begin
                dv_nxt = 1'b0;
            end
            if (lvl_r != '0 && (!dv_r || dma_ready)) begin
                pop = 1'b1;
                dv_nxt = 1'b1;
                dd_nxt = mem_r[rp_r];
            end
        end else if (host_read && lvl_r != '0) begin
            pop = 1'b1;
            hv_nxt = 1'b1;
            hd_nxt = mem_r[rp_r];
        end
        if (overrun_clear || sw_arm) begin
            ovr_nxt = 1'b0;
        end
        if (push) begin
            wp_nxt = wp_r + 1'b1;
            if (full && !pop) begin
                ovr_nxt = 1'b1;
                rp_nxt = rp_r + 1'b1;
            end else if (!pop) begin
                lvl_nxt = lvl_r + 1'b1;
            end
        end
        if (pop) begin
            rp_nxt = rp_r + 1'b1;
            if (!push) begin
                lvl_nxt = lvl_r - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wp_r] <= conv_data;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
            lvl_r <= LEVEL_RESET;
            ovr_r <= 1'b0;
            dv_r <= 1'b0;
            dd_r <= '0;
            hv_r <= 1'b0;
            hd_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            lvl_r <= lvl_nxt;
            ovr_r <= ovr_nxt;
            dv_r <= dv_nxt;
            dd_r <= dd_nxt;
            hv_r <= hv_nxt;
            hd_r <= hd_nxt;
        end
    end

    assign conv_start = conv_r;
    assign mux_chan = chan_r;
    assign programmable_gain_amp = gain_r;
    assign dma_valid = dv_r;
    assign dma_data = dd_r;
    assign host_data = hd_r;
    assign host_data_valid = hv_r;
    assign acq_busy = busy_r;
    assign acq_done = done_r;
    assign overrun_err = ovr_r;
    assign ref_cfg_err = cerr_r;
    assign fifo_level = lvl_r;
endmodule
`default_nettype wire

// File: bench/aqc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module aqc_conv_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // converter side
    input wire logic conv_start,
    output logic conv_done,
    output logic [aqc_pkg::SAMPLE_W-1:0] conv_data
);
    import aqc_pkg::*;
    logic [1:0] wait_r;
    logic [SAMPLE_W-1:0] cnt_r;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wait_r <= 2'h0;
            cnt_r <= 16'h0100;
            conv_done <= 1'b0;
            conv_data <= 16'hffff;
        end else begin
            conv_done <= (wait_r == 2'h1);
            // data line toggles when not valid
            conv_data <= (wait_r == 2'h1) ? cnt_r : ~conv_data;
            if (wait_r == 2'h1) begin
                cnt_r <= cnt_r + 16'h0001;
            end
            if (conv_start) begin
                wait_r <= 2'h3;
            end else if (wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/aqc_acq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module aqc_acq_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // watched ports
    input wire logic hw_paced,
    input wire logic finite_mode,
    input wire logic ref_trig_en,
    input wire logic sw_arm,
    input wire logic sw_stop,
    input wire logic sw_convert,
    input wire logic overrun_clear,
    input wire logic dma_ready,
    input wire logic conv_start,
    input wire logic dma_valid,
    input wire logic [aqc_pkg::SAMPLE_W-1:0] dma_data,
    input wire logic acq_busy,
    input wire logic acq_done,
    input wire logic overrun_err,
    input wire logic ref_cfg_err,
    input wire logic [aqc_pkg::FIFO_AW:0] fifo_level
);
    import aqc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic ok_arm;
    assign ok_arm = sw_arm && hw_paced && !acq_busy;
    sw_conv_cause_a: assert property (conv_start && !hw_paced |-> $past(sw_convert))
        else $error("conversion without command");
    conv_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    ref_reject_a: assert property (ok_arm && ref_trig_en && !finite_mode
        |=> ref_cfg_err && !acq_busy) else $error("reference config not rejected");
    arm_busy_a: assert property (ok_arm && !(ref_trig_en && !finite_mode) |=> acq_busy)
        else $error("arm did not set busy");
    overrun_hold_a: assert property (overrun_err && !overrun_clear && !sw_arm
        |=> overrun_err) else $error("overrun dropped by itself");
    dma_hold_a: assert property (dma_valid && !dma_ready
        |=> dma_valid && $stable(dma_data)) else $error("dma word not held");
    level_max_a: assert property (fifo_level <= 5'h10)
        else $error("fifo level beyond depth");
    stop_halt_a: assert property (sw_stop && hw_paced |-> ##2 !conv_start [*4])
        else $error("conversion after stop");
    done_idle_a: assert property (acq_done |-> !acq_busy)
        else $error("done while busy");
    cover property (conv_start && hw_paced);
    cover property ($rose(overrun_err));
    cover property ($rose(acq_done));
    cover property ($rose(ref_cfg_err));
endmodule
bind aqc_acquisition_control aqc_acq_properties i_aqc_acq_properties (.*);
`default_nettype wire

// File: bench/aqc_acquisition_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module aqc_acquisition_control_test;
    import aqc_pkg::*;
    logic sys_clk = 0, rstn = 0, hw_paced = 0, buffered = 0, finite_mode = 0;
    logic ext_clock_sel = 0, begin_trig_en = 0, begin_trig_falling = 0, ref_trig_en = 0;
    logic ref_trig_falling = 0, pause_en = 0, pause_active_high = 1, analog_trig_sel = 0;
    logic sw_arm = 0, sw_start = 0, sw_stop = 0, sw_convert = 0, overrun_clear = 0;
    logic ext_sample_clk = 0, acq_begin_trigger = 0, acq_reference_stop_trigger = 0;
    logic acq_pause_gate = 0, analog_compare = 0, dma_ready = 1, host_read = 0;
    logic [DIV_W-1:0] sample_div = 16'h0003;
    logic [COUNT_W-1:0] sample_count = 24'h00_0004, pretrig_count = 24'h00_0000;
    logic [CHAN_W-1:0] scan_last = 4'h2;
    logic [RANGE_W-1:0] scan_range [SCAN_LEN];
    logic [CHAN_W-1:0] scan_chan [SCAN_LEN];
    logic conv_start, conv_done, dma_valid, host_data_valid, acq_busy, acq_done;
    logic overrun_err, ref_cfg_err;
    logic [CHAN_W-1:0] mux_chan;
    logic [RANGE_W-1:0] programmable_gain_amp;
    logic [SAMPLE_W-1:0] conv_data, dma_data, host_data;
    logic [FIFO_AW:0] fifo_level;
    int errors = 0, checks = 0, nconv = 0, k, n;
    always #20 sys_clk = ~sys_clk;
    aqc_acquisition_control i_aqc_acquisition_control (.*);
    aqc_conv_model i_aqc_conv_model (.sys_clk(sys_clk), .rstn(rstn),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data));
    always @(posedge sys_clk) if (conv_start === 1'b1) nconv++;
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge sys_clk) s = 0;
    endtask
    task automatic cyc(int c);
        repeat (c) @(negedge sys_clk);
    endtask
    task test_done;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task t_soft;
        begin_trig_en = 1;
        acq_begin_trigger = 1;
        pulse(sw_arm);
        cyc(10);
        chk("busy", 0, acq_busy);
        n = nconv;
        pulse(sw_convert);
        cyc(10);
        chk("convs", n + 1, nconv);
        pulse(host_read);
        chk("host_valid", 1, host_data_valid);
        chk("host_data", 16'h0100, host_data);
        begin_trig_en = 0;
        acq_begin_trigger = 0;
    endtask
    task t_finite;
        hw_paced = 1;
        buffered = 1;
        finite_mode = 1;
        pulse(sw_arm);
        pulse(sw_start);
        k = 0;
        n = nconv;
        for (int i = 0; i < 300; i++) begin
            if (conv_start === 1'b1) begin
                chk("mux", scan_chan[(nconv - n) % 3], mux_chan);
                chk("gain", scan_range[(nconv - n) % 3], programmable_gain_amp);
            end
            if (dma_valid === 1'b1) chk("dma", 16'h0101 + k++, dma_data);
            cyc(1);
        end
        chk("beats", 4, k);
        chk("done", 1, acq_done);
    endtask
    task t_trig;
        finite_mode = 0;
        begin_trig_en = 1;
        pause_en = 1;
        pulse(sw_arm);
        n = nconv;
        cyc(20);
        chk("armed", n, nconv);
        acq_pause_gate = 1;
        acq_begin_trigger = 1;
        cyc(40);
        chk("paused", n, nconv);
        acq_pause_gate = 0;
        cyc(40);
        chk("run", 1, nconv > n + 3);
        chk("busy", 1, acq_busy);
        pulse(sw_stop);
        cyc(1);
        n = nconv;
        chk("stopped", 0, acq_busy);
        cyc(20);
        chk("halted", n, nconv);
        begin_trig_en = 0;
        pause_en = 0;
        acq_begin_trigger = 0;
    endtask
    task t_overrun;
        buffered = 0;
        pulse(sw_arm);
        pulse(sw_start);
        cyc(250);
        chk("overrun", 1, overrun_err);
        chk("level", 5'h10, fifo_level);
        pulse(sw_stop);
        cyc(10);
        chk("sticky", 1, overrun_err);
        pulse(overrun_clear);
        cyc(1);
        chk("cleared", 0, overrun_err);
        ref_trig_en = 1;
        pulse(sw_arm);
        cyc(1);
        chk("ref_cfg", 1, ref_cfg_err);
        chk("ref_idle", 0, acq_busy);
    endtask
    task t_ref;
        buffered = 1;
        finite_mode = 1;
        ref_trig_falling = 1;
        pretrig_count = 24'h00_0002;
        sample_count = 24'h00_0005;
        cyc(20);
        dma_ready = 0;
        acq_reference_stop_trigger = 1;
        pulse(sw_arm);
        chk("ref_accept", 0, ref_cfg_err);
        pulse(sw_start);
        cyc(36);
        chk("dma_wait", 1, dma_valid);
        chk("fifo_hold", 3, fifo_level);
        chk("ref_run", 1, acq_busy);
        dma_ready = 1;
        acq_reference_stop_trigger = 0;
        cyc(2);
        n = nconv;
        cyc(40);
        chk("post", n + 3, nconv);
        chk("ref_done", 1, acq_done);
        chk("ref_stop", 0, acq_busy);
    endtask
    task t_ext;
        ref_trig_en = 0;
        ext_clock_sel = 1;
        sample_count = 24'h00_0002;
        pulse(sw_arm);
        pulse(sw_start);
        n = nconv;
        cyc(20);
        chk("ext_idle", n, nconv);
        repeat (3) begin
            ext_sample_clk = 1;
            cyc(5);
            ext_sample_clk = 0;
            cyc(5);
        end
        chk("ext_convs", n + 2, nconv);
        chk("ext_done", 1, acq_done);
    endtask
    initial begin
        for (int i = 0; i < SCAN_LEN; i++) begin
            scan_chan[i] = CHAN_W'(i == 0 ? 9 : (i == 1 ? 0 : 5));
            scan_range[i] = RANGE_W'(i == 0 ? 6 : 3);
        end
        k = 0;
        cyc(5);
        rstn = 1;
        cyc(1);
        t_soft();
        t_finite();
        t_trig();
        t_overrun();
        t_ref();
        t_ext();
        test_done();
    end
    initial begin
        #(40 * 4000);
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
